// *** pkg/eep_pkg.sv ***
/*
 eeprom program/erase control package: register offsets, field positions,
 reset values, shadow word addresses and timing constants.
 assumes an axi4-lite register bus with 32-bit data.
*/
package eep_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_MCR  = 8'h00;
   localparam logic [7:0] OFF_PROT = 8'h04;
   localparam logic [7:0] OFF_PROG = 8'h08;
   localparam logic [7:0] OFF_DIVH = 8'h0C;
   localparam logic [7:0] OFF_DIVL = 8'h10;
   localparam logic [7:0] OFF_STAT = 8'h14;
   localparam logic [7:0] OFF_WADR = 8'h18;
   localparam logic [7:0] OFF_WDAT = 8'h1C;
   // module config register bits
   localparam int MCR_DBG  = 7;
   localparam int MCR_NOSH = 6;
   localparam int MCR_T5   = 5;
   localparam int MCR_T4   = 4;
   // program control register bits, then protect register bit
   localparam int PRG_AUTO = 5;
   localparam int PRG_BYTE = 4;
   localparam int PRG_ROW  = 3;
   localparam int PRG_ERAS = 2;
   localparam int PRG_LAT  = 1;
   localparam int PRG_PGM  = 0;
   localparam int PROT_SH  = 6;
   // shadow word and reset values
   localparam logic [11:0] SHADOW_HI    = 12'hFC0;
   localparam logic [11:0] SHADOW_LO    = 12'hFC1;
   localparam logic [7:0]  PROT_RESET   = 8'h7F;
   localparam logic [7:0]  MCR_LOW_RST  = 8'h0C;
   // self-time: 35 us pulses, 10 ms cycle
   localparam int PULSE_US   = 35;
   localparam int PROG_MS    = 10;
   localparam int PULSES     = (PROG_MS * 1000) / PULSE_US;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : eep_pkg

// *** logic/eep_pulse.sv ***
/*
 self-time pulse generator: one sys_clk pulse every clock_divider clocks.
 assumes sys_clk is the oscillator clock; stops while divider is zero.
*/
module eep_pulse
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   // control
   input  wire logic       run,
   input  wire logic [9:0] divider,
   // pulse out
   output logic            tick
);
   logic [9:0] count;

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || !run || divider == 10'h000)
      begin
         count <= 10'h000;
         tick  <= 1'b0;
      end
      else if (count + 10'h001 >= divider)
      begin
         count <= 10'h000;
         tick  <= 1'b1;
      end
      else
      begin
         count <= count + 10'h001;
         tick  <= 1'b0;
      end
   end
endmodule : eep_pulse

// *** logic/eep_ctrl.sv ***
/*
 eeprom program/erase controller with shadow word reload and divider lock.
 assumes an axi4-lite master and an eeprom array with 12-bit byte address,
 a shadow word store, and a one-cycle array read.
*/
// How it works
// - auto mode: hardware clears voltage enable when cycle ends
// - further operations allowed with latch held, no array read needed
// - shadow word replaces array bytes FC0/FC1 while shadow disable is zero
// - every reset copies shadow word into config and divider registers
// - shadow high: 7 debug, 6 shadow disable, 5:4 test, 1:0 divider
// - shadow low byte loads divider low eight bits at reset
// - normal mode: only first divider write after reset made with latch clear is accepted
// - voltage enable sets only if latch already set
// - no program or erase cycle starts while divider is zero
module eep_ctrl
#(
   parameter int PULSE_COUNT = eep_pkg::PULSES
)
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   // mode strap, pin
   input  wire logic        normal_mode_flag,
   // axi4-lite write
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // shadow word store
   input  wire logic [15:0] shadow_word,
   // array control
   output logic [11:0]      arr_addr,
   output logic [7:0]       arr_wdata,
   output logic             arr_sel_shadow,
   output logic             arr_erase,
   output logic [1:0]       arr_erase_size,
   output logic             arr_hv,
   output logic             latch_enable,
   output logic             debug_lockout_disable
);
   ////////////////////////////////////////////////////////////////////////
   typedef enum logic [2:0]
   {
      ST_LOAD = 3'b001,
      ST_IDLE = 3'b010,
      ST_RUN  = 3'b100
   } eep_state_e;

   eep_state_e  state;
   logic        mode_sync1;
   logic        mode_sync2;
   logic [7:0]  module_config_reg;
   logic [7:0]  block_protect_reg;
   logic [7:0]  prog_reg;
   logic [1:0]  divider_high;
   logic [7:0]  divider_low;
   logic        div_locked;
   logic [11:0] lat_addr;
   logic [7:0]  lat_data;
   logic        lat_valid;
   logic [15:0] pulse_cnt;
   logic        tick;
   logic        aw_held;
   logic        w_held;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        wr_go;
   logic        wr_ok;
   logic        program_voltage_enable;
   logic        shadow_disable;
   logic [9:0]  clock_divider;
   logic        done;

   assign program_voltage_enable = prog_reg[eep_pkg::PRG_PGM];
   assign shadow_disable         = module_config_reg[eep_pkg::MCR_NOSH];
   assign clock_divider          = {divider_high, divider_low};
   assign latch_enable           = prog_reg[eep_pkg::PRG_LAT];
   assign debug_lockout_disable  = module_config_reg[eep_pkg::MCR_DBG];

   ////////////////////////////////////////////////////////////////////////
   // mode pin synchroniser
   always_ff @(posedge sys_clk)
   begin
      mode_sync1 <= normal_mode_flag;
      mode_sync2 <= mode_sync1;
   end

   ////////////////////////////////////////////////////////////////////////
   // axi write channel capture
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign wr_go         = aw_held && w_held && !s_axi_bvalid;
   assign wr_ok         = aw_addr <= eep_pkg::OFF_WDAT && aw_addr[1:0] == 2'h0;

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 8'h00;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= eep_pkg::RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? eep_pkg::RESP_OKAY : eep_pkg::RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // shadow reload, config and protect registers
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         state             <= ST_LOAD;
         module_config_reg <= eep_pkg::MCR_LOW_RST;
         block_protect_reg <= eep_pkg::PROT_RESET;
      end
      else
      begin
         unique case (state)
            ST_LOAD:
            begin
               module_config_reg <= {shadow_word[15:12],
                  eep_pkg::MCR_LOW_RST[3:0]};
               state <= ST_IDLE;
            end
            ST_IDLE, ST_RUN:
            begin
               state <= program_voltage_enable ? ST_RUN : ST_IDLE;
               if (wr_go && w_strb[0] && aw_addr == eep_pkg::OFF_MCR
                  && !mode_sync2)
                  module_config_reg <= w_data[7:0];
               if (wr_go && w_strb[0] && aw_addr == eep_pkg::OFF_PROT
                  && !program_voltage_enable)
                  block_protect_reg <= w_data[7:0];
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // divider with write-once lock in normal mode
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         divider_high <= 2'h0;
         divider_low  <= 8'h00;
         div_locked   <= 1'b0;
      end
      else if (state == ST_LOAD)
      begin
         divider_high <= shadow_word[9:8];
         divider_low  <= shadow_word[7:0];
      end
      else if (wr_go && w_strb[0] && !latch_enable && !div_locked
         && (aw_addr == eep_pkg::OFF_DIVH || aw_addr == eep_pkg::OFF_DIVL))
      begin
         if (aw_addr == eep_pkg::OFF_DIVH)
            divider_high <= w_data[1:0];
         else
            divider_low <= w_data[7:0];
         div_locked <= mode_sync2;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // program control and latch
   assign done = program_voltage_enable && prog_reg[eep_pkg::PRG_AUTO]
      && pulse_cnt >= 16'(PULSE_COUNT);

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         prog_reg <= 8'h00;
      else if (done)
         prog_reg[eep_pkg::PRG_PGM] <= 1'b0;
      else if (wr_go && w_strb[0] && aw_addr == eep_pkg::OFF_PROG)
      begin
         if (!program_voltage_enable)
         begin
            prog_reg[7:1] <= {2'h0, w_data[5:2],
               (clock_divider != 10'h000) ? w_data[1] : latch_enable};
            prog_reg[eep_pkg::PRG_PGM] <= w_data[0] && latch_enable
               && lat_valid && clock_divider != 10'h000;
         end
         else
            prog_reg[eep_pkg::PRG_PGM] <= w_data[0];
      end
   end

   // data latch; writes ignored during high voltage
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || !latch_enable)
      begin
         lat_addr  <= 12'h000;
         lat_data  <= 8'h00;
         lat_valid <= 1'b0;
      end
      else if (wr_go && w_strb[0] && !program_voltage_enable
         && aw_addr == eep_pkg::OFF_WDAT)
      begin
         lat_addr  <= w_data[19:8];
         lat_data  <= w_data[7:0];
         lat_valid <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // self-time pulse counting
   eep_pulse eep_pulse_inst
   (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .run     (program_voltage_enable),
      .divider (clock_divider),
      .tick    (tick)
   );

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || !program_voltage_enable)
         pulse_cnt <= 16'h0000;
      else if (tick)
         pulse_cnt <= pulse_cnt + 16'h0001;
   end

   ////////////////////////////////////////////////////////////////////////
   // array outputs
   assign arr_hv         = program_voltage_enable;
   assign arr_addr       = lat_addr;
   assign arr_wdata      = lat_data;
   assign arr_erase      = prog_reg[eep_pkg::PRG_ERAS];
   assign arr_erase_size = {prog_reg[eep_pkg::PRG_BYTE],
      prog_reg[eep_pkg::PRG_ROW]};
   assign arr_sel_shadow = !shadow_disable && (lat_addr == eep_pkg::SHADOW_HI
      || lat_addr == eep_pkg::SHADOW_LO);

   ////////////////////////////////////////////////////////////////////////
   // axi read channel
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= eep_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= eep_pkg::RESP_OKAY;
         unique case (s_axi_araddr)
            eep_pkg::OFF_MCR:  s_axi_rdata <= {24'h0, module_config_reg};
            eep_pkg::OFF_PROT: s_axi_rdata <= {24'h0, block_protect_reg};
            eep_pkg::OFF_PROG: s_axi_rdata <= {24'h0, prog_reg};
            eep_pkg::OFF_DIVH: s_axi_rdata <= {30'h0, divider_high};
            eep_pkg::OFF_DIVL: s_axi_rdata <= {24'h0, divider_low};
            eep_pkg::OFF_STAT: s_axi_rdata <= {29'h0, arr_sel_shadow,
               div_locked, lat_valid};
            eep_pkg::OFF_WADR: s_axi_rdata <= {20'h0, lat_addr};
            eep_pkg::OFF_WDAT: s_axi_rdata <= {24'h0, lat_data};
            default:
            begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= eep_pkg::RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // assertions
   AST_HV_NEEDS_LATCH: assert property (@(posedge sys_clk)
      disable iff (sys_rst) program_voltage_enable |-> latch_enable)
      else $error("voltage enable without latch");
   AST_NO_START_DIV0: assert property (@(posedge sys_clk)
      disable iff (sys_rst) $rose(program_voltage_enable) |->
      clock_divider != 10'h000) else $error("zero divider start");
   AST_AUTO_CLEAR: assert property (@(posedge sys_clk)
      disable iff (sys_rst) done |=> !program_voltage_enable)
      else $error("auto clear missed");
   AST_LOCK_HOLDS: assert property (@(posedge sys_clk)
      disable iff (sys_rst) div_locked && state != ST_LOAD |=>
      $stable(clock_divider)) else $error("locked divider changed");
   AST_RELOAD: assert property (@(posedge sys_clk)
      disable iff (sys_rst) state == ST_LOAD |=>
      divider_low == $past(shadow_word[7:0])) else $error("no low reload");
   AST_RELOAD_HI: assert property (@(posedge sys_clk)
      disable iff (sys_rst) state == ST_LOAD |=>
      shadow_disable == $past(shadow_word[14])) else $error("no high reload");
   AST_SHADOW_MAP: assert property (@(posedge sys_clk)
      disable iff (sys_rst) shadow_disable |-> !arr_sel_shadow)
      else $error("shadow mapped while disabled");
   AST_TIMED: assert property (@(posedge sys_clk)
      disable iff (sys_rst) $fell(program_voltage_enable)
      && prog_reg[eep_pkg::PRG_AUTO] && $past(pulse_cnt) < 16'(PULSE_COUNT)
      |-> 1'b0) else $error("auto cycle ended early");
endmodule : eep_ctrl

// *** tb/tb_eep_ctrl.sv ***
/*
 bench for eep_ctrl: axi4-lite master, shadow reload, divider lock,
 manual and self-timed cycles. assumes eep_pkg offsets, PULSE_COUNT of 3.
*/
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
   miscompares++; $display("[ERR] %0t got=%h exp=%h", $time, a, b); end end

module tb_eep_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PC = 3;
   logic        sys_clk, sys_rst, normal_mode_flag;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [15:0] shadow_word;
   logic [11:0] arr_addr;
   logic [7:0]  arr_wdata;
   logic [1:0]  arr_erase_size;
   logic        arr_sel_shadow, arr_erase, arr_hv;
   logic        latch_enable, debug_lockout_disable;
   int          miscompares, total_checks, cyc, seed, n, i;
   logic [31:0] rq_e[$], rq_m[$], ee, em;
   logic [1:0]  rq_r[$], bq[$], eb, er;
   logic [7:0]  v, d;
   logic [11:0] a;
   logic [15:0] sw;

   eep_ctrl #(.PULSE_COUNT(PC)) eep_ctrl_inst
   (
      .sys_clk, .sys_rst, .normal_mode_flag,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .shadow_word, .arr_addr, .arr_wdata,
      .arr_sel_shadow, .arr_erase, .arr_erase_size, .arr_hv,
      .latch_enable, .debug_lockout_disable
   );

   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [7:0] ad, input logic [31:0] dt,
                     input logic [1:0] rs);
      logic aw_d, w_d;
      bq.push_back(rs);
      aw_d = 1'b0;
      w_d  = 1'b0;
      s_axi_awaddr  <= ad;
      s_axi_wdata   <= dt;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      while (!(aw_d && w_d))
      begin
         @(posedge sys_clk);
         if (!aw_d && s_axi_awready === 1'b1)
         begin
            aw_d = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_d && s_axi_wready === 1'b1)
         begin
            w_d = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
   endtask : wr

   task automatic rd(input logic [7:0] ad, input logic [31:0] e, m,
                     input logic [1:0] rs);
      rq_e.push_back(e & m);
      rq_m.push_back(m);
      rq_r.push_back(rs);
      s_axi_araddr  <= ad;
      s_axi_arvalid <= 1'b1;
      do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
   endtask : rd

   task automatic rst_dut(input logic [15:0] w, input logic nm);
      shadow_word      <= w;
      normal_mode_flag <= nm;
      sys_rst          <= 1'b1;
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge sys_clk);
   endtask : rst_dut

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : wrap_up

   ////////////////////////////////////////////////////////////////////////
   always @(posedge sys_clk)
   begin
      cyc++;
      if (s_axi_bvalid === 1'b1 && s_axi_bready)
      begin
         if (bq.size() == 0) miscompares++;
         else
         begin
            eb = bq.pop_front();
            `CHK(s_axi_bresp, eb)
         end
      end
      if (s_axi_rvalid === 1'b1 && s_axi_rready)
      begin
         if (rq_e.size() == 0) miscompares++;
         else
         begin
            ee = rq_e.pop_front();
            em = rq_m.pop_front();
            er = rq_r.pop_front();
            `CHK(s_axi_rdata & em, ee)
            `CHK(s_axi_rresp, er)
         end
      end
      if (cyc == 20000)
      begin
         miscompares++;
         wrap_up();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      seed = 73776;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= '0;
      s_axi_wstrb  <= 4'hF;
      s_axi_bready <= 1'b1;
      s_axi_rready <= 1'b1;
      // special mode, zero divider from shadow
      rst_dut(16'hBC00, 1'b0);
      rd(eep_pkg::OFF_DIVL, 32'h0, 32'hFF, eep_pkg::RESP_OKAY);
      wr(eep_pkg::OFF_PROG, 32'h2, eep_pkg::RESP_OKAY);
      rd(eep_pkg::OFF_PROG, 32'h0, 32'h3, eep_pkg::RESP_OKAY);
      v = 8'(($random(seed) & 7) + 4);
      wr(eep_pkg::OFF_DIVL, 32'h5, eep_pkg::RESP_OKAY);
      wr(eep_pkg::OFF_DIVL, 32'(v), eep_pkg::RESP_OKAY);
      rd(eep_pkg::OFF_DIVL, 32'(v), 32'hFF, eep_pkg::RESP_OKAY);
      wr(eep_pkg::OFF_PROT, 32'h3F, eep_pkg::RESP_OKAY);
      rd(eep_pkg::OFF_PROT, 32'h3F, 32'hFF, eep_pkg::RESP_OKAY);
      wr(eep_pkg::OFF_MCR, 32'h3C, eep_pkg::RESP_OKAY);
      rd(eep_pkg::OFF_MCR, 32'h3C, 32'hFF, eep_pkg::RESP_OKAY);
      wr(eep_pkg::OFF_PROG, 32'h6, eep_pkg::RESP_OKAY);
      wr(eep_pkg::OFF_WDAT, {12'h0, eep_pkg::SHADOW_HI, 8'hFC},
         eep_pkg::RESP_OKAY);
      `CHK({arr_sel_shadow, arr_wdata}, {1'b1, 8'hFC})
      wr(eep_pkg::OFF_PROG, 32'h0, eep_pkg::RESP_OKAY);
      wr(eep_pkg::OFF_PROT, 32'h7F, eep_pkg::RESP_OKAY);
      rd(eep_pkg::OFF_PROT, 32'h7F, 32'hFF, eep_pkg::RESP_OKAY);
      wr(eep_pkg::OFF_MCR, 32'h4C, eep_pkg::RESP_OKAY);
      wr(eep_pkg::OFF_PROG, 32'h2, eep_pkg::RESP_OKAY);
      `CHK(latch_enable, 1'b1)
      wr(eep_pkg::OFF_WDAT, {12'h0, eep_pkg::SHADOW_HI, 8'h5A},
         eep_pkg::RESP_OKAY);
      `CHK(arr_sel_shadow, 1'b0)
      // normal mode, shadow reload on second reset
      sw = {1'($random(seed)), 1'b0, 4'hF, 2'b00, 8'(v - 8'h1)};
      rst_dut(sw, 1'b1);
      `CHK(debug_lockout_disable, sw[15])
      rd(eep_pkg::OFF_MCR, 32'({sw[15:12], eep_pkg::MCR_LOW_RST[3:0]}),
         32'hFF, eep_pkg::RESP_OKAY);
      rd(eep_pkg::OFF_DIVH, 32'(sw[9:8]), 32'h3, eep_pkg::RESP_OKAY);
      rd(eep_pkg::OFF_DIVL, 32'(sw[7:0]), 32'hFF, eep_pkg::RESP_OKAY);
      wr(eep_pkg::OFF_DIVL, 32'(v), eep_pkg::RESP_OKAY);
      wr(eep_pkg::OFF_DIVL, 32'(v ^ 8'h1), eep_pkg::RESP_OKAY);
      wr(eep_pkg::OFF_DIVH, 32'h1, eep_pkg::RESP_OKAY);
      rd(eep_pkg::OFF_DIVL, 32'(v), 32'hFF, eep_pkg::RESP_OKAY);
      rd(eep_pkg::OFF_DIVH, 32'h0, 32'h3, eep_pkg::RESP_OKAY);
      for (i = 0; i < 4; i++)
      begin
         wr(eep_pkg::OFF_PROG, 32'((i << 3) | 6), eep_pkg::RESP_OKAY);
         `CHK({arr_erase, arr_erase_size}, {1'b1, 2'(i)})
      end
      wr(eep_pkg::OFF_PROG, 32'h0, eep_pkg::RESP_OKAY);
      wr(eep_pkg::OFF_PROG, 32'h13, eep_pkg::RESP_OKAY);
      rd(eep_pkg::OFF_PROG, 32'h12, 32'h3F, eep_pkg::RESP_OKAY);
      a = 12'($random(seed) & 12'h7FF);
      d = 8'($random(seed));
      wr(eep_pkg::OFF_WDAT, {12'h0, a, d}, eep_pkg::RESP_OKAY);
      `CHK({arr_addr, arr_wdata}, {a, d})
      wr(eep_pkg::OFF_PROG, 32'h13, eep_pkg::RESP_OKAY);
      `CHK(arr_hv, 1'b1)
      repeat (v * PC * 3) @(posedge sys_clk);
      `CHK(arr_hv, 1'b1)
      wr(eep_pkg::OFF_PROG, 32'h12, eep_pkg::RESP_OKAY);
      `CHK({arr_hv, latch_enable}, 2'b01)
      wr(eep_pkg::OFF_WDAT, {12'h0, eep_pkg::SHADOW_LO, d},
         eep_pkg::RESP_OKAY);
      `CHK({arr_sel_shadow, arr_addr}, {1'b1, eep_pkg::SHADOW_LO})
      wr(eep_pkg::OFF_WDAT, {12'h0, a, ~d}, eep_pkg::RESP_OKAY);
      `CHK({arr_sel_shadow, arr_wdata}, {1'b0, ~d})
      // self-timed cycle
      wr(eep_pkg::OFF_PROG, 32'h32, eep_pkg::RESP_OKAY);
      wr(eep_pkg::OFF_PROG, 32'h33, eep_pkg::RESP_OKAY);
      `CHK(arr_hv, 1'b1)
      n = 0;
      while (arr_hv === 1'b1 && n < 1000)
      begin
         @(posedge sys_clk);
         n++;
      end
      `CHK(n >= v * (PC - 1) && n <= v * (PC + 1) + 4, 1'b1)
      rd(eep_pkg::OFF_PROG, 32'h32, 32'h3F, eep_pkg::RESP_OKAY);
      wr(eep_pkg::OFF_PROG, 32'h0, eep_pkg::RESP_OKAY);
      `CHK(latch_enable, 1'b0)
      wr(8'h40, 32'h0, eep_pkg::RESP_SLVERR);
      rd(8'h40, 32'h0, 32'h0, eep_pkg::RESP_SLVERR);
      repeat (4) @(posedge sys_clk);
      wrap_up();
   end
endmodule : tb_eep_ctrl
